// >>> shared/serial_one_cfg.svh
// Register map, field positions, reset values and bit-rate divisors
// of the second serial port. Included by the port design file and the testbench.
`ifndef SERIAL_ONE_CFG_SVH
`define SERIAL_ONE_CFG_SVH

// Byte offsets on the register bus
`define CTRL_OFS       4'h0
`define AUX_OFS        4'h4
`define DATA_OFS       4'h8
`define BAUD_OFS       4'hC

// Control register fields
`define B_SEL_HI       7
`define B_SEL_LO       6
`define B_MPC          5
`define B_REN          4
`define B_TB8          3
`define B_RB8          2
`define B_TI           1
`define B_RI           0

// Auxiliary register fields
`define B_FE           0
`define B_DBL          1
`define B_RXAV         2
`define B_TXBSY        3

// Reset values
`define CTRL_RST       8'h00
`define BAUD_RST       16'h0057

// Oscillator clocks per bit
`define DIV_SHIFT_SLOW 16'h000C
`define DIV_SHIFT_FAST 16'h0004
`define DIV_FIXED_SLOW 16'h0040
`define DIV_FIXED_FAST 16'h0020
`define BAUD_MIN       16'h0002

// Bit indices inside a frame
`define SHIFT_LAST     4'h7
`define ASYNC10_LAST   4'h9
`define ASYNC11_LAST   4'hA
`define RX10_STOP      4'h8
`define RX11_STOP      4'h9

// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// >>> shared/serial_one_pkg.sv
// Types shared by the serial port design files.
// Assumes the constants header is included where numbers are needed.
package serial_one_pkg;
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_ASYNC10,
    MODE_FIXED11,
    MODE_VAR11
  } frame_mode_t;

  typedef logic [7:0] byte_t;
endpackage

// >>> shared/stream_if.sv
// Valid/ready word stream between the port and its receive buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// >>> rtl/rx_word_buffer.sv
// Small FIFO holding received words until software reads them.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module rx_word_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Stream sides
  stream_if.sink   in_s,
  stream_if.source out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  wire push = in_s.valid && in_s.ready;
  wire pop  = out_s.valid && out_s.ready;

  assign in_s.ready  = cnt_q != CW'(DEPTH);
  assign out_s.valid = cnt_q != '0;
  assign out_s.data  = mem_q[rp_q];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push)
        wp_q <= next_ptr(wp_q);
      if (pop)
        rp_q <= next_ptr(rp_q);
      if (push && !pop)
        cnt_q <= CW'(cnt_q + 1'b1);
      else if (pop && !push)
        cnt_q <= CW'(cnt_q - 1'b1);
    end
  end

  // Storage needs no reset; count and pointers guard it
  always_ff @(posedge aclk) begin
    if (push)
      mem_q[wp_q] <= in_s.data;
  end

  property p_no_overflow;
    @(posedge aclk) disable iff (!aresetn)
      in_s.valid |-> in_s.ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("word offered to a full receive buffer");
endmodule

// >>> rtl/serial_one_port.sv
// Second serial port: shift mode and three asynchronous frame modes,
// AXI4-Lite register slave, two-entry receive buffer.
// Assumes rxd_i is asynchronous; the pad resolves rxd from rxd_o/oe.
`timescale 1ns/10ps
`include "serial_one_cfg.svh"
// Notes on behaviour
// - Transmit done: shift 8th end, async stop start
// - Transmit done flag cleared only by software
// - Mode 0: synchronous 8-bit shift, clk/4 or /12
// - Mode 2 fixed 11-bit clk/32 or /64
// - Mode 0 clock select: 0 is /12, 1 /4
// - Ten-bit mode with check: need valid stop
// - Eleven-bit multiproc: ninth zero drops; capture ninth
// - Bad stop sets sticky framing error flag
module serial_one_port #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Serial pins
  input  wire logic              rxd_i,
  output logic                   rxd_o,
  output logic                   rxd_oe,
  output logic                   txd
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_SHIFT} rx_state_t;

  logic sel_hi_q, sel_lo_q, mpc_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
  logic fe_q, dbl_q;
  logic [15:0] baud_q;
  logic        tx_busy_q;
  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_idx_q;
  logic [3:0]  tx_last_q;
  logic [10:0] tx_sr_q;
  rx_state_t   rx_state_q;
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_idx_q;
  logic [8:0]  rx_sr_q;
  logic        rxd_s1_q, rxd_s2_q, rxd_s3_q;

  stream_if #(.W(8)) push_if ();
  stream_if #(.W(8)) pop_if ();

  rx_word_buffer #(.W(8), .DEPTH(2)) u_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_s    (push_if.sink),
    .out_s   (pop_if.source)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [3:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // Bus decode
  wire wr_hs    = awvalid && awready && wvalid && wready;
  wire rd_hs    = arvalid && arready;
  wire wr_ctrl  = wr_hs && hit(awaddr, `CTRL_OFS) && wstrb[0];
  wire wr_aux   = wr_hs && hit(awaddr, `AUX_OFS) && wstrb[0];
  wire wr_data  = wr_hs && hit(awaddr, `DATA_OFS) && wstrb[0];
  wire wr_baud  = wr_hs && hit(awaddr, `BAUD_OFS);
  wire wr_map   = hit(awaddr, `CTRL_OFS) || hit(awaddr, `AUX_OFS) ||
                  hit(awaddr, `DATA_OFS) || hit(awaddr, `BAUD_OFS);
  wire rd_map   = hit(araddr, `CTRL_OFS) || hit(araddr, `AUX_OFS) ||
                  hit(araddr, `DATA_OFS) || hit(araddr, `BAUD_OFS);
  wire rd_pop   = rd_hs && hit(araddr, `DATA_OFS);

  // Mode and bit timing
  serial_one_pkg::frame_mode_t mode;
  assign mode = serial_one_pkg::frame_mode_t'({sel_hi_q, sel_lo_q});
  wire is_shift = mode == serial_one_pkg::MODE_SHIFT;
  wire nine     = sel_hi_q;
  wire [15:0] shift_len = mpc_q ? `DIV_SHIFT_FAST : `DIV_SHIFT_SLOW;
  wire [15:0] fixed_len = dbl_q ? `DIV_FIXED_FAST : `DIV_FIXED_SLOW;
  wire [15:0] var_len   = (baud_q < `BAUD_MIN) ? `BAUD_MIN : baud_q;
  wire [15:0] bit_len   = is_shift ? shift_len :
                          (mode == serial_one_pkg::MODE_FIXED11) ?
                          fixed_len : var_len;
  wire [15:0] half_len  = {1'b0, bit_len[15:1]};

  // Transmit decode
  wire tx_tick  = tx_cnt_q == 16'(bit_len - 16'h0001);
  wire tx_start = wr_data && !tx_busy_q && rx_state_q != RX_SHIFT;
  wire ti_set   = tx_busy_q && tx_tick &&
                  (is_shift ? tx_idx_q == `SHIFT_LAST
                            : tx_idx_q == 4'(tx_last_q - 4'h1));

  // Receive decode
  wire rx_tick  = rx_cnt_q == 16'(bit_len - 16'h0001);
  wire rx_half  = rx_cnt_q == 16'(half_len - 16'h0001);
  wire rx_go    = ren_q && push_if.ready;
  wire fall     = rxd_s3_q && !rxd_s2_q;
  wire [3:0] rx_stop_idx = nine ? `RX11_STOP : `RX10_STOP;
  wire [8:0] rx_sh       = {rxd_s2_q, rx_sr_q[8:1]};
  wire rx_stop_tick  = rx_state_q == RX_BITS && rx_tick &&
                       rx_idx_q == rx_stop_idx;
  wire rx_shift_done = rx_state_q == RX_SHIFT && rx_tick &&
                       rx_idx_q == `SHIFT_LAST;
  wire stop_ok  = rxd_s2_q;
  wire rx_keep  = nine ? !(mpc_q && !rx_sr_q[8])
                       : !(mpc_q && !stop_ok);
  wire ri_set   = rx_shift_done || (rx_stop_tick && rx_keep);
  wire fe_set   = rx_stop_tick && !stop_ok;

  assign push_if.valid = ri_set;
  assign push_if.data  = rx_shift_done ? rx_sh[8:1] :
                         nine ? rx_sr_q[7:0] : rx_sr_q[8:1];
  assign pop_if.ready  = rd_pop;

  wire [7:0] ctrl_rd = {sel_hi_q, sel_lo_q, mpc_q, ren_q,
                        tb8_q, rb8_q, ti_q, ri_q};
  wire [7:0] aux_rd  = {4'h0, tx_busy_q, pop_if.valid, dbl_q, fe_q};
  wire [7:0] data_rd = pop_if.valid ? pop_if.data : 8'h00;
  wire [31:0] rd_val = hit(araddr, `CTRL_OFS) ? {24'h00_0000, ctrl_rd} :
                       hit(araddr, `AUX_OFS)  ? {24'h00_0000, aux_rd} :
                       hit(araddr, `DATA_OFS) ? {24'h00_0000, data_rd} :
                       hit(araddr, `BAUD_OFS) ? {16'h0000, baud_q} :
                       32'h0000_0000;

  // Bus slave: address and data taken together, one of each in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= `RESP_OKAY;
      rdata   <= 32'h0000_0000;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !awready && !bvalid;
      arready <= arvalid && !arready && !rvalid;
      if (wr_hs) begin
        bvalid <= 1'b1;
        bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (rd_hs) begin
        rvalid <= 1'b1;
        rresp  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
        rdata  <= rd_val;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Registers; a hardware set beats a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sel_hi_q, sel_lo_q, mpc_q, ren_q, tb8_q, rb8_q, ti_q, ri_q}
        <= `CTRL_RST;
      fe_q   <= 1'b0;
      dbl_q  <= 1'b0;
      baud_q <= `BAUD_RST;
    end else begin
      if (wr_ctrl) begin
        sel_hi_q <= wdata[`B_SEL_HI];
        sel_lo_q <= wdata[`B_SEL_LO];
        mpc_q    <= wdata[`B_MPC];
        ren_q    <= wdata[`B_REN];
        tb8_q    <= wdata[`B_TB8];
      end
      ti_q <= ti_set || (ti_q && !(wr_ctrl && !wdata[`B_TI]));
      ri_q <= ri_set || (ri_q && !(wr_ctrl && !wdata[`B_RI]));
      fe_q <= fe_set || (fe_q && !(wr_aux && !wdata[`B_FE]));
      if (rx_stop_tick && rx_keep)
        rb8_q <= nine ? rx_sr_q[8] : stop_ok;
      else if (wr_ctrl)
        rb8_q <= wdata[`B_RB8];
      if (wr_aux)
        dbl_q <= wdata[`B_DBL];
      if (wr_baud && wstrb[0])
        baud_q[7:0] <= wdata[7:0];
      if (wr_baud && wstrb[1])
        baud_q[15:8] <= wdata[15:8];
    end
  end

  // Transmitter; a data write while busy is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 16'h0000;
      tx_idx_q  <= 4'h0;
      tx_last_q <= 4'h0;
      tx_sr_q   <= 11'h7FF;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q  <= 16'h0000;
      tx_idx_q  <= 4'h0;
      tx_last_q <= is_shift ? `SHIFT_LAST :
                   nine ? `ASYNC11_LAST : `ASYNC10_LAST;
      tx_sr_q   <= is_shift ? {3'h7, wdata[7:0]} :
                   {1'b1, nine ? tb8_q : 1'b1, wdata[7:0], 1'b0};
    end else if (tx_busy_q && tx_tick) begin
      tx_cnt_q <= 16'h0000;
      tx_idx_q <= 4'(tx_idx_q + 4'h1);
      tx_sr_q  <= {1'b1, tx_sr_q[10:1]};
      if (tx_idx_q == tx_last_q)
        tx_busy_q <= 1'b0;
    end else if (tx_busy_q) begin
      tx_cnt_q <= 16'(tx_cnt_q + 16'h0001);
    end
  end

  // Pins; in shift mode txd is the shift clock, low in each bit's first half
  wire shift_run = tx_busy_q || rx_state_q == RX_SHIFT;
  wire [15:0] shift_cnt = tx_busy_q ? tx_cnt_q : rx_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd      <= 1'b1;
      rxd_o    <= 1'b1;
      rxd_oe   <= 1'b0;
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      rxd_s3_q <= 1'b1;
    end else begin
      txd      <= is_shift ? !(shift_run && shift_cnt < half_len)
                           : (!tx_busy_q || tx_sr_q[0]);
      rxd_o    <= tx_sr_q[0];
      rxd_oe   <= is_shift && tx_busy_q;
      rxd_s1_q <= rxd_i;
      rxd_s2_q <= rxd_s1_q;
      rxd_s3_q <= rxd_s2_q;
    end
  end

  // Receiver; a new frame starts only while the buffer has room
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 16'h0000;
      rx_idx_q   <= 4'h0;
      rx_sr_q    <= 9'h000;
    end else begin
      unique case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= 16'h0000;
          rx_idx_q <= 4'h0;
          if (rx_go && is_shift && !ri_q && !tx_busy_q)
            rx_state_q <= RX_SHIFT;
          else if (rx_go && !is_shift && fall)
            rx_state_q <= RX_START;
        end
        RX_START: begin
          if (rx_half) begin
            rx_cnt_q   <= 16'h0000;
            rx_state_q <= rxd_s2_q ? RX_IDLE : RX_BITS;
          end else begin
            rx_cnt_q <= 16'(rx_cnt_q + 16'h0001);
          end
        end
        RX_BITS, RX_SHIFT: begin
          if (rx_tick) begin
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 4'(rx_idx_q + 4'h1);
            rx_sr_q  <= rx_sh;
            if (rx_stop_tick || rx_shift_done)
              rx_state_q <= RX_IDLE;
          end else begin
            rx_cnt_q <= 16'(rx_cnt_q + 16'h0001);
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ti_shift;
    tx_busy_q && tx_tick && is_shift && tx_idx_q == 4'h7 |=> ti_q;
  endproperty
  a_ti_shift: assert property (p_ti_shift)
    else $error("transmit done not set after 8th shift bit");

  property p_ti_stop;
    tx_busy_q && tx_tick && !is_shift && tx_idx_q == 4'(tx_last_q - 4'h1)
      |=> ti_q ##1 txd;
  endproperty
  a_ti_stop: assert property (p_ti_stop)
    else $error("transmit done not set at stop bit start");

  property p_ti_hold;
    ti_q && !(wr_ctrl && !wdata[`B_TI]) |=> ti_q;
  endproperty
  a_ti_hold: assert property (p_ti_hold)
    else $error("transmit done cleared without software");

  property p_shift_slow;
    tx_busy_q && tx_tick && is_shift && !mpc_q && !wr_ctrl &&
      tx_idx_q < 4'h6 |-> ##12 tx_tick;
  endproperty
  a_shift_slow: assert property (p_shift_slow)
    else $error("shift mode bit not 12 clocks");

  property p_shift_fast;
    tx_busy_q && tx_tick && is_shift && mpc_q && !wr_ctrl &&
      tx_idx_q < 4'h6 |-> ##1 !tx_tick [*3] ##1 tx_tick;
  endproperty
  a_shift_fast: assert property (p_shift_fast)
    else $error("fast shift mode bit not 4 clocks");

  property p_fixed_rate;
    tx_busy_q && tx_tick && mode == serial_one_pkg::MODE_FIXED11 &&
      !dbl_q && !wr_ctrl && !wr_aux && tx_idx_q < 4'h9 |-> ##64 tx_tick;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate)
    else $error("fixed rate bit not 64 clocks");

  property p_stop_check;
    rx_stop_tick && !nine && mpc_q && !stop_ok |=> ri_q == $past(ri_q);
  endproperty
  a_stop_check: assert property (p_stop_check)
    else $error("receive done raised on bad stop with check on");

  property p_ninth_filter;
    rx_stop_tick && nine && mpc_q && !rx_sr_q[8]
      |=> ri_q == $past(ri_q) && !push_if.valid;
  endproperty
  a_ninth_filter: assert property (p_ninth_filter)
    else $error("address filter let a zero ninth bit through");

  property p_ninth_capture;
    rx_stop_tick && nine && rx_keep |=> rb8_q == $past(rx_sr_q[8]);
  endproperty
  a_ninth_capture: assert property (p_ninth_capture)
    else $error("ninth bit not captured");

  property p_fe_set;
    rx_stop_tick && !stop_ok |=> fe_q [*2];
  endproperty
  a_fe_set: assert property (p_fe_set)
    else $error("framing error not held after bad stop");

  property p_ri_hold;
    ri_q && !(wr_ctrl && !wdata[`B_RI]) |=> ri_q;
  endproperty
  a_ri_hold: assert property (p_ri_hold)
    else $error("receive done cleared without software");

  c_tx_done: cover property ($rose(ti_q));
  c_rx_done: cover property ($rose(ri_q) ##[1:200] rd_pop);
  c_frame_err: cover property ($rose(fe_q));
endmodule

// >>> bench/serial_peer.sv
// Remote serial peer: sends asynchronous frames, captures the port's
// asynchronous frames and its shift-mode output.
// Assumes the receive line has a pull-up and that the port runs on aclk.
`timescale 1ns/10ps
module serial_peer (
  // Clock
  input  wire logic aclk,
  // Port pins
  input  wire logic txd,
  input  wire logic rxd_o,
  input  wire logic rxd_oe,
  output logic      rxd_i
);
  logic line_q = 1'b1;

  // Pull-up: a released line reads high
  assign rxd_i = rxd_oe ? rxd_o : line_q;

  task automatic send(input logic [7:0] d, input logic n9, input bit has9,
                      input logic stp, input int bl);
    logic [10:0] f;
    int          nb;
    f  = has9 ? {stp, n9, d, 1'b0} : {1'b0, stp, d, 1'b0};
    nb = has9 ? 11 : 10;
    for (int i = 0; i < nb; i++) begin
      @(posedge aclk);
      line_q <= f[i];
      repeat (bl - 1) @(posedge aclk);
    end
    @(posedge aclk);
    line_q <= 1'b1;
  endtask

  // Samples each bit in its middle, counted from the start edge
  task automatic grab_async(input bit has9, input int bl,
                            output logic [7:0] d, output logic n9,
                            output logic stp);
    @(negedge txd);
    repeat (bl / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bl) @(posedge aclk);
      d[i] = txd;
    end
    n9 = 1'b0;
    if (has9) begin
      repeat (bl) @(posedge aclk);
      n9 = txd;
    end
    repeat (bl) @(posedge aclk);
    stp = txd;
  endtask

  // Shift clock rises mid-bit, so data is sampled there
  task automatic grab_shift(output logic [7:0] d, output int per);
    time t0;
    t0  = 0;
    per = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      d[i] = rxd_i;
      if (i == 0) t0 = $time;
      if (i == 1) per = int'(($time - t0) / 100);
    end
  endtask
endmodule

// >>> bench/testbench.sv
// Self-checking bench of the serial port over its register bus.
// Assumes the constants header is on the include path.
`timescale 1ns/10ps
`include "serial_one_cfg.svh"
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [3:0]  araddr = 4'h0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        rxd_i;
  logic        rxd_o;
  logic        rxd_oe;
  logic        txd;
  int          bad_count = 0;
  int          comparisons = 0;
  logic [1:0]  r;
  logic [31:0] v;
  logic [7:0]  d;
  logic        n9;
  logic        stp;
  int          per;
  logic [7:0]  tx_ctrl [4] = '{8'h88, 8'h88, 8'h40, 8'hC8};
  logic [7:0]  tx_aux [4] = '{8'h02, 8'h00, 8'h00, 8'h00};
  int          tx_bl [4] = '{int'(`DIV_FIXED_FAST), int'(`DIV_FIXED_SLOW),
                             16, 16};
  bit          tx_n9 [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  serial_one_port #(.ADDR_W(4)) serial_one_port_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd(txd)
  );

  serial_peer serial_peer_inst (
    .aclk(aclk), .txd(txd), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .rxd_i(rxd_i)
  );

  initial begin
    forever #50 aclk = ~aclk;
  end

  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic wr(input logic [3:0] a, input logic [31:0] dat,
                    output logic [1:0] resp);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] dat,
                    output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    dat  = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] mask);
    comparisons++;
    if ((got & mask) !== (exp & mask)) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Rx helper: frame from the peer, then settle before reading
  task automatic rx(input logic [7:0] b, input logic n, input bit h,
                    input logic s);
    serial_peer_inst.send(b, n, h, s, 16);
    repeat (20) @(posedge aclk);
  endtask

  initial begin
    #(20000 * 100);
    bad_count++;
    end_sim;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CTRL_OFS, v, r);
    chk(v, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`BAUD_OFS, v, r);
    chk(v, 32'h0000_0057, 32'hFFFF_FFFF);
    rd(4'h2, v, r);
    chk(r, `RESP_SLVERR, 32'h0000_0003);
    wr(4'h6, 32'h0000_00FF, r);
    chk(r, `RESP_SLVERR, 32'h0000_0003);
    wr(`BAUD_OFS, 32'h0000_0010, r);
    chk(r, `RESP_OKAY, 32'h0000_0003);
    for (int k = 0; k < 4; k++) begin
      wr(`AUX_OFS, tx_aux[k], r);
      wr(`CTRL_OFS, tx_ctrl[k], r);
      fork
        wr(`DATA_OFS, 32'h0000_00A5, r);
        serial_peer_inst.grab_async(tx_n9[k], tx_bl[k], d, n9, stp);
      join
      chk(d, 32'h0000_00A5, 32'h0000_00FF);
      chk(n9, tx_n9[k], 32'h0000_0001);
      chk(stp, 1'b1, 32'h0000_0001);
      repeat (100) @(posedge aclk);
      rd(`CTRL_OFS, v, r);
      chk(v, 32'h0000_0002, 32'h0000_0002);
    end
    wr(`CTRL_OFS, 32'h0000_0000, r);
    rd(`CTRL_OFS, v, r);
    chk(v, 32'h0000_0000, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      wr(`CTRL_OFS, (k == 0) ? 32'h0000_0020 : 32'h0000_0000, r);
      fork
        wr(`DATA_OFS, 32'h0000_003C, r);
        serial_peer_inst.grab_shift(d, per);
      join
      chk(d, 32'h0000_003C, 32'h0000_00FF);
      chk(per, (k == 0) ? `DIV_SHIFT_FAST : `DIV_SHIFT_SLOW,
          32'h0000_FFFF);
      repeat (20) @(posedge aclk);
      rd(`CTRL_OFS, v, r);
      chk(v, 32'h0000_0002, 32'h0000_0002);
    end
    // Third word finds the two-entry buffer full and is lost
    wr(`CTRL_OFS, 32'h0000_0050, r);
    rx(8'h11, 1'b0, 1'b0, 1'b1);
    rx(8'h22, 1'b0, 1'b0, 1'b1);
    rx(8'h33, 1'b0, 1'b0, 1'b1);
    rd(`CTRL_OFS, v, r);
    chk(v, 32'h0000_0005, 32'h0000_0005);
    rd(`DATA_OFS, v, r);
    chk(v, 32'h0000_0011, 32'hFFFF_FFFF);
    rd(`DATA_OFS, v, r);
    chk(v, 32'h0000_0022, 32'hFFFF_FFFF);
    rd(`DATA_OFS, v, r);
    chk(v, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(`CTRL_OFS, 32'h0000_0070, r);
    rx(8'h44, 1'b0, 1'b0, 1'b0);
    rd(`CTRL_OFS, v, r);
    chk(v, 32'h0000_0000, 32'h0000_0001);
    rd(`AUX_OFS, v, r);
    chk(v, 32'h0000_0001, 32'h0000_0005);
    wr(`AUX_OFS, 32'h0000_0000, r);
    rd(`AUX_OFS, v, r);
    chk(v, 32'h0000_0000, 32'h0000_0001);
    wr(`CTRL_OFS, 32'h0000_00F0, r);
    rx(8'h3C, 1'b0, 1'b1, 1'b1);
    rd(`CTRL_OFS, v, r);
    chk(v, 32'h0000_0000, 32'h0000_0001);
    rx(8'h5A, 1'b1, 1'b1, 1'b1);
    rd(`CTRL_OFS, v, r);
    chk(v, 32'h0000_0005, 32'h0000_0005);
    rd(`DATA_OFS, v, r);
    chk(v, 32'h0000_005A, 32'hFFFF_FFFF);
    end_sim;
  end
endmodule
